//--- ltss_pkg.sv
`default_nettype none

package ltss_pkg;

    // Core clock rate and the reference measurement cycle.
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SCAN_PERIOD_MS  = 100;
    localparam int unsigned SCAN_PERIOD_CYC = (CLK_HZ / 1000) * SCAN_PERIOD_MS;

    // Interval timer width and its reset period value.
    localparam int unsigned TMR_W         = 12;
    localparam logic [11:0] TMR_PERIOD_RST = 12'hFFF;

    // Least settle time, in base-clock cycles, between suspend release and start.
    localparam int unsigned SUSP_SETTLE_CYC = 64;

    // Number of touch channels in one scan and cycles spent on each.
    localparam int unsigned CHAN_N   = 8;
    localparam int unsigned CHAN_CYC = 16;

    // Touch unit states, one-hot.
    typedef enum logic [3:0] {
        LTSS_ST_SUSPEND = 4'h1,
        LTSS_ST_WAIT    = 4'h2,
        LTSS_ST_SCAN    = 4'h4,
        LTSS_ST_DONE    = 4'h8
    } ltss_state_type;

endpackage

`default_nettype wire

//--- ltss_top.sv
// How it works
// - A 12-bit interval timer holds a programmed period and counts continuously once started.
// - The timer raises one tick pulse per period, which spaces the touch scans.
// - With software start selected and suspend enabled the touch unit parks in suspend.
// - The tick pulse is also the wake request that brings the processor out of stop.
// - The host does the start procedure and the unit then leaves suspend and scans on trigger.
// - The done pulse comes only after every configured channel has been measured.
// - After reporting completion the unit waits for the next start.
// - Writing the suspend enable bit 1 enables suspend and writing 0 disables it.
`timescale 1ns/100ps
`default_nettype none

module ltss_top #(
    parameter int unsigned CHANS    = ltss_pkg::CHAN_N,
    parameter int unsigned CHAN_CYC = ltss_pkg::CHAN_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        tmr_start_i,
    input  wire logic [11:0] tmr_period_i,
    input  wire logic        sw_trig_sel_i,
    input  wire logic        suspend_enable_bit_i,
    input  wire logic        scan_start_i,
    output logic             interval_tick_irq_o,
    output logic             cpu_wake_o,
    output logic             scan_done_irq_o,
    output logic             suspended_o,
    output logic             waiting_o,
    output logic             scanning_o,
    output logic [7:0]       chan_idx_o
);

    ////////////////////////////////////////////////////////////////////////////
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    logic        run_q;
    logic [11:0] cnt_q;
    logic        tick_q;
    wire         cnt_wrap = (cnt_q >= tmr_period_i);

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_q  <= 1'b0;
            cnt_q  <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            if (tmr_start_i) begin
                run_q <= 1'b1;
            end
            if (run_q) begin
                cnt_q <= cnt_wrap ? 12'h000 : cnt_q + 12'h001;
            end
            tick_q <= run_q && cnt_wrap;
        end
    end

    assign interval_tick_irq_o = tick_q;
    assign cpu_wake_o = tick_q;

    ////////////////////////////////////////////////////////////////////////////
    ltss_pkg::ltss_state_type st_q;
    ltss_pkg::ltss_state_type st_d;
    logic [7:0]  ch_q;
    logic [15:0] dwell_q;
    logic        done_q;

    wire dwell_end = (dwell_q == 16'(CHAN_CYC - 1));
    wire last_ch   = (ch_q == 8'(CHANS - 1));
    wire susp_req  = sw_trig_sel_i && suspend_enable_bit_i;
    wire start_ok  = scan_start_i && !suspend_enable_bit_i;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ltss_pkg::LTSS_ST_SUSPEND: begin
                if (!suspend_enable_bit_i) begin
                    st_d = ltss_pkg::LTSS_ST_WAIT;
                end
            end
            ltss_pkg::LTSS_ST_WAIT: begin
                if (susp_req) begin
                    st_d = ltss_pkg::LTSS_ST_SUSPEND;
                end else if (start_ok) begin
                    st_d = ltss_pkg::LTSS_ST_SCAN;
                end
            end
            ltss_pkg::LTSS_ST_SCAN: begin
                if (dwell_end && last_ch) begin
                    st_d = ltss_pkg::LTSS_ST_DONE;
                end
            end
            ltss_pkg::LTSS_ST_DONE: begin
                st_d = ltss_pkg::LTSS_ST_WAIT;
            end
            default: st_d = ltss_pkg::LTSS_ST_WAIT;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ltss_pkg::LTSS_ST_WAIT;
            ch_q    <= 8'h00;
            dwell_q <= 16'h0000;
            done_q  <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ltss_pkg::LTSS_ST_SCAN) begin
                dwell_q <= dwell_end ? 16'h0000 : dwell_q + 16'h0001;
                if (dwell_end) begin
                    ch_q <= ch_q + 8'h01;
                end
            end else begin
                dwell_q <= 16'h0000;
                ch_q    <= 8'h00;
            end
            done_q <= (st_d == ltss_pkg::LTSS_ST_DONE) && (st_q == ltss_pkg::LTSS_ST_SCAN);
        end
    end

    assign scan_done_irq_o = done_q;
    assign suspended_o     = (st_q == ltss_pkg::LTSS_ST_SUSPEND);
    assign waiting_o       = (st_q == ltss_pkg::LTSS_ST_WAIT);
    assign scanning_o      = (st_q == ltss_pkg::LTSS_ST_SCAN);
    assign chan_idx_o      = ch_q;

    ////////////////////////////////////////////////////////////////////////////
    property p_tick_period;
        @(posedge core_clk_i) disable iff (!rst_n)
        run_q && !cnt_wrap |=> cnt_q == $past(cnt_q) + 12'h001;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("timer stalled");

    property p_tick_on_wrap;
        @(posedge core_clk_i) disable iff (!rst_n)
        run_q && cnt_wrap |=> interval_tick_irq_o && cnt_q == 12'h000;
    endproperty
    a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("no tick at wrap");

    property p_tick_pulse;
        @(posedge core_clk_i) disable iff (!rst_n)
        interval_tick_irq_o && tmr_period_i != 12'h000 |=> !interval_tick_irq_o;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");

    property p_wake;
        @(posedge core_clk_i) disable iff (!rst_n)
        interval_tick_irq_o == cpu_wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not tied to tick");

    property p_enter_susp;
        @(posedge core_clk_i) disable iff (!rst_n)
        waiting_o && sw_trig_sel_i && suspend_enable_bit_i |=> suspended_o;
    endproperty
    a_enter_susp: assert property (p_enter_susp) else $error("suspend not entered");

    property p_leave_susp;
        @(posedge core_clk_i) disable iff (!rst_n)
        suspended_o && !suspend_enable_bit_i |=> waiting_o;
    endproperty
    a_leave_susp: assert property (p_leave_susp) else $error("suspend not released");

    property p_done_after_all;
        @(posedge core_clk_i) disable iff (!rst_n)
        scan_done_irq_o |-> $past(scanning_o) && $past(chan_idx_o) == 8'(CHANS - 1);
    endproperty
    a_done_after_all: assert property (p_done_after_all) else $error("early done");

    // The done pulse is shown from the done state, so waiting follows one cycle later.
    property p_idle_after;
        @(posedge core_clk_i) disable iff (!rst_n)
        scan_done_irq_o |=> waiting_o;
    endproperty
    a_idle_after: assert property (p_idle_after) else $error("no wait after done");

    property p_ignore_start;
        @(posedge core_clk_i) disable iff (!rst_n)
        (!waiting_o || suspend_enable_bit_i) && !scanning_o |=> !scanning_o;
    endproperty
    a_ignore_start: assert property (p_ignore_start) else $error("bad scan start");

    property p_done_once;
        @(posedge core_clk_i) disable iff (!rst_n)
        scan_done_irq_o |=> !scan_done_irq_o [*2];
    endproperty
    a_done_once: assert property (p_done_once) else $error("done repeated");

    c_tick: cover property (@(posedge core_clk_i) disable iff (!rst_n) interval_tick_irq_o);
    c_susp: cover property (@(posedge core_clk_i) disable iff (!rst_n) suspended_o ##1 waiting_o);
    c_scan: cover property (@(posedge core_clk_i) disable iff (!rst_n) scan_done_irq_o);
    c_refused: cover property (@(posedge core_clk_i) disable iff (!rst_n)
        waiting_o && scan_start_i && suspend_enable_bit_i);

endmodule // ltss_top

`default_nettype wire

//--- ltss_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ltss_host_model (
    input  wire logic core_clk_i,
    input  wire logic go_i,
    input  wire logic rogue_i,
    input  wire logic nosel_i,
    input  wire logic tick_i,
    input  wire logic done_i,
    output logic      busy_o,
    output logic      suspend_enable_bit_o,
    output logic      sw_trig_sel_o,
    output logic      scan_start_o
);
    initial begin
        busy_o = 1'b0;
        suspend_enable_bit_o = 1'b0;
        sw_trig_sel_o = 1'b1;
        scan_start_o = 1'b0;
    end

    task automatic pulse();
        scan_start_o <= 1'b1;
        @(posedge core_clk_i);
        scan_start_o <= 1'b0;
    endtask

    // Each go runs three full low-power cycles; rogue and nosel are deliberate misuse.
    always begin
        @(posedge core_clk_i);
        if (go_i) begin
            busy_o <= 1'b1;
            repeat (3) begin
                sw_trig_sel_o <= !nosel_i;
                suspend_enable_bit_o <= 1'b1;
                repeat (2) @(posedge core_clk_i);
                if (rogue_i) pulse();
                do @(posedge core_clk_i); while (tick_i !== 1'b1);
                suspend_enable_bit_o <= 1'b0;
                repeat (ltss_pkg::SUSP_SETTLE_CYC) @(posedge core_clk_i);
                pulse();
                if (rogue_i) begin
                    @(posedge core_clk_i);
                    pulse();
                end
                while (done_i !== 1'b1) @(posedge core_clk_i);
            end
            busy_o <= 1'b0;
        end
    end
endmodule // ltss_host_model

`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int NCH = 5;
    localparam int CYC = 6;
    logic        clk, rst_n, tmr_start, go, rogue, nosel, busy, susp, sel, trig;
    logic        tick, wake, done, susp_o, wait_o, scan_o, r1, r2, tmr_on, done_x;
    logic [11:0] per;
    logic [7:0]  chan;
    int          bad_count = 0;
    int          n_tests = 0;
    int          st, age;
    int          gap[2], seen[2];

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ltss_top #(.CHANS(NCH), .CHAN_CYC(CYC)) u_ltss_top (
        .core_clk_i(clk), .rst_n_i(rst_n), .tmr_start_i(tmr_start), .tmr_period_i(per),
        .sw_trig_sel_i(sel), .suspend_enable_bit_i(susp), .scan_start_i(trig),
        .interval_tick_irq_o(tick), .cpu_wake_o(wake), .scan_done_irq_o(done),
        .suspended_o(susp_o), .waiting_o(wait_o), .scanning_o(scan_o), .chan_idx_o(chan));

    ltss_host_model u_ltss_host_model (
        .core_clk_i(clk), .go_i(go), .rogue_i(rogue), .nosel_i(nosel), .tick_i(tick),
        .done_i(done), .busy_o(busy), .suspend_enable_bit_o(susp), .sw_trig_sel_o(sel),
        .scan_start_o(trig));

    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Mirrors the design's two-flop reset release so the model steps in lock with it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) {r2, r1} <= 2'b00;
        else {r2, r1} <= {r1, 1'b1};
    end

    // Reference model: 0 suspend, 1 wait, 2 scan, 3 done; age counts scan cycles from 1.
    always @(posedge clk) begin
        logic [1:0] tk;
        tk = {wake, tick};
        if (r2 !== 1'b1) begin
            st = 1;
            age = 0;
            done_x = 1'b0;
            tmr_on = 1'b0;
            seen = '{0, 0};
            gap = '{0, 0};
        end else begin
            check("suspended", susp_o, st == 0);
            check("waiting", wait_o, st == 1);
            check("scanning", scan_o, st == 2);
            check("channel", chan, (st == 2) ? (age - 1) / CYC : (st == 3) ? NCH : 0);
            check("done", done, done_x);
            for (int i = 0; i < 2; i++) begin
                check("tick early", tk[i] & !tmr_on, 0);
                if (tk[i] === 1'b1 && seen[i] != 0) check("tick gap", gap[i], per + 1);
                check("tick due", gap[i] <= per + 3, 1);
                if (tk[i] === 1'b1) seen[i] = 1;
                if (tk[i] === 1'b1) gap[i] = 0;
                if (tmr_on) gap[i]++;
            end
            done_x = 1'b0;
            case (st)
                0: if (!susp) st = 1;
                1: if (susp && sel) st = 0;
                   else if (trig && !susp) begin
                       st = 2;
                       age = 1;
                   end
                2: if (age == NCH * CYC) begin
                    st = 3;
                    done_x = 1'b1;
                end else age++;
                default: begin
                    st = 1;
                    age = 0;
                end
            endcase
            if (tmr_start) tmr_on = 1'b1;
        end
    end

    initial begin
        rst_n = 1'b0;
        tmr_start = 1'b0;
        per = 12'h000;
        go = 1'b0;
        rogue = 1'b0;
        nosel = 1'b0;
        void'($urandom(4704));
        for (int t = 0; t < 4; t++) begin
            per <= (t == 0) ? 12'h005 : (t == 3) ? 12'hFFF : 12'(100 + $urandom % 500);
            rogue <= (t < 2) | 1'($urandom % 2);
            nosel <= (t == 1);
            rst_n <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            repeat (3) @(posedge clk);
            tmr_start <= 1'b1;
            go <= 1'b1;
            @(posedge clk);
            tmr_start <= 1'b0;
            go <= 1'b0;
            repeat (2) @(posedge clk);
            while (busy) @(posedge clk);
            check("ticks seen", seen[0] & seen[1], 1);
            $display("test %0d period %0d finished", t, per);
        end
        final_report();
    end

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule // testbench

`default_nettype wire
